// ===== design/mas_mux.sv
`timescale 1ns/1ns
// Summary of operation
// - column strobe low only with column address
// - two column strobes per bank, per byte
// - sram mode reuses strobes as byte selects
// - sram byte selects active low, two banks
// - dram or sram chosen by firmware setting
// - active-low os rom select on access
// - rom select decodes direct or translated address
// - dram address pins carry row then column
// - sram mode drives address bits 12 to 23
// - other cycles except internal i/o drive upper bus address bits
// - row strobe per bank with row address
// - one write strobe for dram and sram
module mas_mux
  import mas_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // configuration, steady while cycles run
  input  wire logic                      cfg_sram_mode,        // 1: sram main memory
  input  wire logic                      cfg_rom_translated,   // 1: rom decodes windowed addr
  // cycle request, from core logic on sys_clk
  input  wire logic                      cyc_start,            // one-cycle pulse
  input  wire logic                      cyc_sys_mem,          // targets system memory
  input  wire logic                      cyc_int_io,           // targets internal i/o
  input  wire logic                      cyc_write,            // write cycle
  input  wire logic                      cyc_hi_byte,          // upper byte lane
  input  wire logic                      cyc_lo_byte,          // lower byte lane
  input  wire logic [MAS_SYS_ADDR_W-1:0] cyc_addr,             // direct physical address
  input  wire logic [MAS_SYS_ADDR_W-1:0] cyc_win_addr,         // translated address
  input  wire logic                      cyc_rom_direct_hit,   // rom range, direct decode
  input  wire logic                      cyc_rom_win_hit,      // rom range, window decode
  // memory pins
  output logic [3:0]                     col_strobe_n,         // bank1h,bank1l,bank0h,bank0l
  output logic [1:0]                     row_strobe_per_bank,  // active low, one per bank
  output logic                           mem_write_strobe_n,
  output logic                           os_rom_select_n,
  output logic [MAS_MA_W-1:0]            mem_addr_out,
  output logic [MAS_COL_W-1:0]           lower_bus_addr,       // address bits 11..1
  // status
  output logic                           cyc_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mas_state_e                 state_q, state_d;        // sequencer
  logic [1:0]                 cnt_q, cnt_d;            // phase counter
  logic [MAS_SYS_ADDR_W-1:0]  addr_q, addr_d;          // captured address
  logic                       sram_q, sram_d;          // captured mode
  logic                       write_q, write_d;
  logic                       hi_q, hi_d;
  logic                       lo_q, lo_d;
  logic                       rom_q, rom_d;            // rom hit of this cycle
  logic [3:0]                 col_q, col_d;
  logic [1:0]                 row_q, row_d;
  logic                       we_q, we_d;
  logic                       romsel_q, romsel_d;
  logic [MAS_MA_W-1:0]        ma_q, ma_d;
  logic [MAS_COL_W-1:0]       la_q, la_d;
  logic                       busy_q, busy_d;
  logic                       lane_en;                 // lane decoder enable
  logic [3:0]                 lanes_n;                 // decoded byte strobes

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // upper address field shared by sram and non-memory cycles
  function automatic logic [MAS_MA_W-1:0] upper_bits(input logic [MAS_SYS_ADDR_W-1:0] a);
    upper_bits = a[MAS_UPPER_LSB +: MAS_MA_W];
  endfunction

  // byte lane strobes share one decoder for dram and sram
  mas_lane_decode u_lanes (
    .bank      (addr_q[MAS_BANK_BIT]),
    .hi_byte   (hi_q),
    .lo_byte   (lo_q),
    .enable    (lane_en),
    .strobes_n (lanes_n)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pins are updated one cycle after the state that wants them, so an
  // address always settles before its strobe falls
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    sram_d   = sram_q;
    write_d  = write_q;
    hi_d     = hi_q;
    lo_d     = lo_q;
    rom_d    = rom_q;
    col_d    = MAS_STROBES_IDLE;
    row_d    = MAS_ROWS_IDLE;
    we_d     = 1'b1;
    romsel_d = 1'b1;
    ma_d     = ma_q;
    la_d     = la_q;
    busy_d   = busy_q;
    lane_en  = 1'b0;
    case (state_q)
      MAS_IDLE: begin
        busy_d = 1'b0;
        if (cyc_start) begin
          addr_d  = cyc_addr;
          sram_d  = cfg_sram_mode;
          write_d = cyc_write;
          hi_d    = cyc_hi_byte;
          lo_d    = cyc_lo_byte;
          // translated or direct decode picks both hit and address
          rom_d   = cfg_rom_translated ? cyc_rom_win_hit : cyc_rom_direct_hit;
          if (cfg_rom_translated) begin
            addr_d = cyc_win_addr;
          end
          busy_d  = 1'b1;
          cnt_d   = 2'h0;
          if (cyc_sys_mem && !cfg_sram_mode) begin
            state_d = MAS_ROW;
            ma_d    = {1'b0, cyc_addr[MAS_ROW_LSB +: MAS_COL_W]};
          end else if (cyc_sys_mem) begin
            state_d = MAS_STAT;
            ma_d    = upper_bits(cyc_addr);
            la_d    = cyc_addr[MAS_COL_LSB +: MAS_COL_W];
          end else if (cyc_int_io) begin
            state_d = MAS_DONE;                // internal i/o leaves pins alone
          end else begin
            state_d = MAS_STAT;
            ma_d    = upper_bits(cfg_rom_translated ? cyc_win_addr : cyc_addr);
            la_d    = cyc_addr[MAS_COL_LSB +: MAS_COL_W];
          end
        end
      end
      MAS_ROW: begin
        // row address already on pins, assert row strobe of the bank
        row_d = addr_q[MAS_BANK_BIT] ? 2'h1 : 2'h2;
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == 2'(MAS_ROW_CYCLES - 1)) begin
          ma_d    = {1'b0, addr_q[MAS_COL_LSB +: MAS_COL_W]};
          cnt_d   = 2'h0;
          state_d = MAS_COL;
        end
      end
      MAS_COL: begin
        // row strobe stays low through the column phase
        row_d   = addr_q[MAS_BANK_BIT] ? 2'h1 : 2'h2;
        // column address was driven last cycle, only now strobe
        lane_en = 1'b1;
        col_d   = lanes_n;
        we_d    = ~write_q;
        cnt_d   = cnt_q + 2'h1;
        if (cnt_q == 2'(MAS_COL_CYCLES - 1)) begin
          state_d = MAS_DONE;
        end
      end
      MAS_STAT: begin
        // sram byte selects or rom select for one access phase
        lane_en  = sram_q;
        col_d    = lanes_n;
        we_d     = ~(write_q & sram_q);
        romsel_d = ~rom_q;
        cnt_d    = cnt_q + 2'h1;
        if (cnt_q == 2'(MAS_COL_CYCLES - 1)) begin
          state_d = MAS_DONE;
        end
      end
      MAS_DONE: begin
        // strobes return high for one cycle before the next request
        busy_d  = 1'b0;
        state_d = MAS_IDLE;
      end
      default: begin
        state_d = MAS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset puts every strobe in its idle high level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q  <= MAS_IDLE;
      cnt_q    <= 2'h0;
      addr_q   <= '0;
      sram_q   <= 1'b0;
      write_q  <= 1'b0;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
      rom_q    <= 1'b0;
      col_q    <= MAS_STROBES_IDLE;
      row_q    <= MAS_ROWS_IDLE;
      we_q     <= 1'b1;
      romsel_q <= 1'b1;
      ma_q     <= MAS_MA_RESET;
      la_q     <= '0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      sram_q   <= sram_d;
      write_q  <= write_d;
      hi_q     <= hi_d;
      lo_q     <= lo_d;
      rom_q    <= rom_d;
      col_q    <= col_d;
      row_q    <= row_d;
      we_q     <= we_d;
      romsel_q <= romsel_d;
      ma_q     <= ma_d;
      la_q     <= la_d;
      busy_q   <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops
  // ----------------------------------------------------------------
  assign col_strobe_n        = col_q;
  assign row_strobe_per_bank = row_q;
  assign mem_write_strobe_n  = we_q;
  assign os_rom_select_n     = romsel_q;
  assign mem_addr_out        = ma_q;
  assign lower_bus_addr      = la_q;
  assign cyc_busy            = busy_q;

endmodule

// ===== design/mas_pkg.sv
package mas_pkg;

  // ----------------------------------------------------------------
  // widths of the memory pin interface
  // ----------------------------------------------------------------
  localparam int MAS_SYS_ADDR_W = 24;        // system address, byte granular
  localparam int MAS_MA_W       = 12;        // memory address pins
  localparam int MAS_COL_W      = 11;        // multiplexed row/column width

  // ----------------------------------------------------------------
  // field positions within the system address
  // ----------------------------------------------------------------
  localparam int MAS_UPPER_LSB  = 12;        // start of upper_bus_addr
  localparam int MAS_ROW_LSB    = 12;        // dram row taken from here
  localparam int MAS_COL_LSB    = 1;         // dram column taken from here
  localparam int MAS_BANK_BIT   = 23;        // bank select bit for dram/sram

  // ----------------------------------------------------------------
  // reset values: every strobe and select idles high
  // ----------------------------------------------------------------
  localparam logic [3:0]  MAS_STROBES_IDLE = 4'hF;
  localparam logic [1:0]  MAS_ROWS_IDLE    = 2'h3;
  localparam logic [11:0] MAS_MA_RESET     = 12'h000;

  // ----------------------------------------------------------------
  // cycle counts of the dram access sequence
  // ----------------------------------------------------------------
  localparam int MAS_ROW_CYCLES = 2;         // row address to column switch
  localparam int MAS_COL_CYCLES = 2;         // column strobe width

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MAS_IDLE  = 3'b000,
    MAS_ROW   = 3'b001,
    MAS_COL   = 3'b010,
    MAS_STAT  = 3'b011,
    MAS_DONE  = 3'b100
  } mas_state_e;

endpackage

// ===== design/mas_lane_decode.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// byte lane decoder: request lanes and bank to four active-low strobes
// ----------------------------------------------------------------
module mas_lane_decode
  import mas_pkg::*;
(
  // request
  input  wire logic       bank,       // 1 selects bank1
  input  wire logic       hi_byte,    // upper byte lane wanted
  input  wire logic       lo_byte,    // lower byte lane wanted
  input  wire logic       enable,     // strobes may assert
  // result, order bank1-high, bank1-low, bank0-high, bank0-low
  output logic [3:0]      strobes_n
);

  // one strobe per byte of each 16-bit bank
  always_comb begin
    strobes_n = MAS_STROBES_IDLE;
    if (enable) begin
      strobes_n[3] = ~(bank & hi_byte);
      strobes_n[2] = ~(bank & lo_byte);
      strobes_n[1] = ~(~bank & hi_byte);
      strobes_n[0] = ~(~bank & lo_byte);
    end
  end

endmodule

// ===== tb/mas_mem_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// external dram: latches the address at each strobe fall
// ------------------------------------------------------------
module mas_mem_model
  import mas_pkg::*;
(
  // pins from the controller
  input  wire logic                sys_clk,
  input  wire logic [1:0]          row_strobe_per_bank,
  input  wire logic [3:0]          col_strobe_n,
  input  wire logic [MAS_MA_W-1:0] mem_addr_out,
  // what the memory saw
  output logic      [MAS_MA_W-1:0] row_seen_q,
  output logic      [MAS_MA_W-1:0] col_seen_q
);
  logic [1:0] row_last_q; // previous levels, to find falling strobes
  logic [3:0] col_last_q;
  // a real part samples on the strobe edge, so only falls latch
  always_ff @(posedge sys_clk) begin
    row_last_q <= row_strobe_per_bank;
    col_last_q <= col_strobe_n;
    if (|(~row_strobe_per_bank & row_last_q)) begin
      row_seen_q <= mem_addr_out;
    end
    if (|(~col_strobe_n & col_last_q)) begin
      col_seen_q <= mem_addr_out;
    end
  end
endmodule

// ===== tb/mas_mux_monitor.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// pin checker for the address and strobe mux
// ------------------------------------------------------------
module mas_mux_monitor
  import mas_pkg::*;
(
  // clock, reset, configuration
  input wire logic                      sys_clk, rst, cfg_sram_mode, cfg_rom_translated,
  // request
  input wire logic                      cyc_start, cyc_sys_mem, cyc_int_io, cyc_write,
  input wire logic                      cyc_hi_byte, cyc_lo_byte,
  input wire logic                      cyc_rom_direct_hit, cyc_rom_win_hit,
  input wire logic [MAS_SYS_ADDR_W-1:0] cyc_addr, cyc_win_addr,
  // memory pins and status
  input wire logic [3:0]                col_strobe_n,
  input wire logic [1:0]                row_strobe_per_bank,
  input wire logic                      mem_write_strobe_n, os_rom_select_n, cyc_busy,
  input wire logic [MAS_MA_W-1:0]       mem_addr_out,
  input wire logic [MAS_COL_W-1:0]      lower_bus_addr
);
  logic [3:0] lane_sel;  // wanted lanes, bank1h..bank0l
  logic       rom_hit;   // hit of whichever decode is configured
  logic       idle_pins; // all strobes and selects parked high
  assign lane_sel  = {cyc_addr[23] & cyc_hi_byte, cyc_addr[23] & cyc_lo_byte,
                      !cyc_addr[23] & cyc_hi_byte, !cyc_addr[23] & cyc_lo_byte};
  assign rom_hit   = cfg_rom_translated ? cyc_rom_win_hit : cyc_rom_direct_hit;
  assign idle_pins = col_strobe_n == MAS_STROBES_IDLE && row_strobe_per_bank == MAS_ROWS_IDLE
                     && mem_write_strobe_n && os_rom_select_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // accepted requests; busy must be low two edges running
  sequence s_take;  cyc_start && !cyc_busy && !$past(cyc_busy); endsequence
  sequence s_dram;  s_take ##0 (!cfg_sram_mode && cyc_sys_mem); endsequence
  sequence s_sram;  s_take ##0 (cfg_sram_mode && cyc_sys_mem); endsequence
  sequence s_other; s_take ##0 (!cyc_sys_mem && !cyc_int_io); endsequence
  sequence s_io;    s_take ##0 (cyc_int_io && !cyc_sys_mem); endsequence
  sequence s_row_held; (row_strobe_per_bank != MAS_ROWS_IDLE) [*4]; endsequence
  a_dram_row_addr: assert property (s_dram |=> mem_addr_out == {1'b0, $past(cyc_addr[22:12])})
    else $error("row address wrong");
  a_row_window: assert property (s_dram |-> ##2 s_row_held ##1 row_strobe_per_bank == MAS_ROWS_IDLE)
    else $error("row strobe window wrong");
  a_dram_col_addr: assert property (s_dram |-> ##3 mem_addr_out == {1'b0, $past(cyc_addr[11:1], 3)})
    else $error("column address wrong");
  a_dram_lanes: assert property (s_dram |-> ##4 col_strobe_n == ~$past(lane_sel, 4))
    else $error("column strobe lanes wrong");
  a_col_with_row: assert property ((!cfg_sram_mode && col_strobe_n != MAS_STROBES_IDLE) |->
    (row_strobe_per_bank != MAS_ROWS_IDLE && $stable(mem_addr_out))) else $error("column strobe alone");
  a_sram_addr: assert property (s_sram |=> mem_addr_out == $past(cyc_addr[23:12])
    && lower_bus_addr == $past(cyc_addr[11:1])) else $error("sram address wrong");
  a_sram_select: assert property (s_sram |-> ##2 col_strobe_n == ~$past(lane_sel, 2))
    else $error("sram byte select wrong");
  a_other_addr: assert property (s_other ##0 !cfg_rom_translated |=>
    mem_addr_out == $past(cyc_addr[23:12])) else $error("upper bus address wrong");
  a_rom_select: assert property (s_other ##0 rom_hit |-> ##2 !os_rom_select_n [*2]
    ##1 os_rom_select_n) else $error("rom select wrong");
  a_io_quiet: assert property (s_io |=> (idle_pins && $stable(mem_addr_out)) [*2])
    else $error("internal io moved pins");
  a_write_phase: assert property (!mem_write_strobe_n |->
    (cfg_sram_mode || col_strobe_n != MAS_STROBES_IDLE)) else $error("write strobe misplaced");
  a_idle_parked: assert property (!cyc_busy |-> idle_pins)
    else $error("strobe active while idle");
  a_reset_park: assert property (disable iff (1'b0) rst |=> idle_pins && !cyc_busy
    && mem_addr_out == MAS_MA_RESET) else $error("reset state wrong");
endmodule
bind mas_mux mas_mux_monitor u_mas_mux_monitor (.sys_clk, .rst, .cfg_sram_mode,
  .cfg_rom_translated, .cyc_start, .cyc_sys_mem, .cyc_int_io, .cyc_write, .cyc_hi_byte,
  .cyc_lo_byte, .cyc_rom_direct_hit, .cyc_rom_win_hit, .cyc_addr, .cyc_win_addr,
  .col_strobe_n, .row_strobe_per_bank, .mem_write_strobe_n, .os_rom_select_n, .cyc_busy,
  .mem_addr_out, .lower_bus_addr);

// ===== tb/test_mas_mux.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("BAD %s exp=%0h got=%0h", n, e, g); end end
module test_mas_mux
  import mas_pkg::*;
;
  logic sys_clk, rst, cfg_sram_mode, cfg_rom_translated, cyc_start, cyc_sys_mem, cyc_int_io;
  logic cyc_write, cyc_hi_byte, cyc_lo_byte, cyc_rom_direct_hit, cyc_rom_win_hit;
  logic [23:0] cyc_addr, cyc_win_addr;
  logic [3:0]  col_strobe_n;
  logic [1:0]  row_strobe_per_bank;
  logic        mem_write_strobe_n, os_rom_select_n, cyc_busy;
  logic [11:0] mem_addr_out, row_seen, col_seen;
  logic [10:0] lower_bus_addr;
  // snapshots taken at each falling edge after a request
  logic [11:0] ma_s[8];
  logic [10:0] lba_s[8];
  logic [3:0]  col_s[8];
  logic [1:0]  row_s[8];
  logic        we_s[8], rom_s[8];
  int          errors, samples_checked;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  mas_mux u_mas_mux (.sys_clk, .rst, .cfg_sram_mode, .cfg_rom_translated, .cyc_start,
    .cyc_sys_mem, .cyc_int_io, .cyc_write, .cyc_hi_byte, .cyc_lo_byte, .cyc_addr, .cyc_win_addr,
    .cyc_rom_direct_hit, .cyc_rom_win_hit, .col_strobe_n, .row_strobe_per_bank,
    .mem_write_strobe_n, .os_rom_select_n, .mem_addr_out, .lower_bus_addr, .cyc_busy);
  mas_mem_model u_mas_mem_model (.sys_clk, .row_strobe_per_bank, .col_strobe_n, .mem_addr_out,
    .row_seen_q(row_seen), .col_seen_q(col_seen));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one request; the extra edge keeps busy low two edges before it
  task automatic issue(input logic [23:0] a);
    int k;
    @(negedge sys_clk);
    for (k = 0; k < 20 && cyc_busy !== 1'b0; k++) @(negedge sys_clk);
    if (k == 20) begin
      errors++;
      report_and_stop();
    end
    cyc_addr = a;
    cyc_win_addr = a;
    cyc_start = 1'b1;
    for (k = 1; k < 8; k++) begin
      @(negedge sys_clk);
      cyc_start = 1'b0;
      {ma_s[k], lba_s[k], col_s[k]} = {mem_addr_out, lower_bus_addr, col_strobe_n};
      {row_s[k], we_s[k], rom_s[k]} = {row_strobe_per_bank, mem_write_strobe_n, os_rom_select_n};
    end
  endtask
  task automatic t_reset;
    `CHK("reset pins", 8'hFD, {col_strobe_n, row_strobe_per_bank, cyc_busy, mem_write_strobe_n})
    `CHK("reset addr", MAS_MA_RESET, mem_addr_out)
    $display("test reset done");
  endtask
  task automatic t_dram(input logic [23:0] a, input logic hi, lo, wr);
    logic [3:0] ln;
    ln = ~{a[23] & hi, a[23] & lo, !a[23] & hi, !a[23] & lo};
    {cfg_sram_mode, cyc_sys_mem, cyc_int_io} = 3'b010;
    {cyc_write, cyc_hi_byte, cyc_lo_byte} = {wr, hi, lo};
    issue(a);
    `CHK("row addr", {1'b0, a[22:12]}, ma_s[1])
    `CHK("row strobe", a[23] ? 2'b01 : 2'b10, row_s[2])
    `CHK("col addr", {1'b0, a[11:1]}, ma_s[3])
    `CHK("col strobes", ln, col_s[4])
    `CHK("col second", ln, col_s[5])
    `CHK("dram write", !wr, we_s[4])
    `CHK("row phase write", 1'b1, we_s[3])
    `CHK("dram end", 4'hF, col_s[6])
    `CHK("model row", {1'b0, a[22:12]}, row_seen)
    `CHK("model col", {1'b0, a[11:1]}, col_seen)
    $display("test dram done");
  endtask
  task automatic t_sram;
    int i;
    logic [23:0] a;
    {cfg_sram_mode, cyc_sys_mem, cyc_int_io} = 3'b110;
    for (i = 0; i < 4; i++) begin
      a = {i[1], 11'h5A3 ^ 11'(i), 12'hC96};
      {cyc_hi_byte, cyc_lo_byte, cyc_write} = {i[0], !i[0], i[0]};
      issue(a);
      `CHK("sram upper", a[23:12], ma_s[1])
      `CHK("sram lower", a[11:1], lba_s[1])
      `CHK("byte select", ~(4'h1 << i), col_s[2])
      `CHK("select hold", ~(4'h1 << i), col_s[3])
      `CHK("sram write", !i[0], we_s[2])
      `CHK("no row strobe", 2'h3, row_s[2])
      `CHK("sram end", 4'hF, col_s[4])
    end
    $display("test sram done");
  endtask
  task automatic t_other;
    int j;
    logic [11:0] m;
    {cfg_sram_mode, cyc_sys_mem, cyc_hi_byte, cyc_lo_byte, cyc_write} = 5'h00;
    for (j = 0; j < 4; j++) begin
      {cfg_rom_translated, cyc_rom_direct_hit, cyc_rom_win_hit} = {j[1], j[0], !j[0]};
      issue(24'hFF_0123 ^ 24'(j << 20));
      `CHK("upper bus addr", cyc_addr[23:12], ma_s[1])
      `CHK("other lower addr", cyc_addr[11:1], lba_s[1])
      `CHK("rom select", j[1] == j[0], rom_s[2])
      `CHK("rom release", 1'b1, rom_s[4])
    end
    {cfg_rom_translated, cyc_int_io, cyc_rom_direct_hit} = 3'b011;
    m = mem_addr_out;
    issue(24'h12_3456);
    `CHK("io pins", 7'h7F, {col_s[2], row_s[2], rom_s[2]})
    `CHK("io addr", m, ma_s[2])
    cyc_int_io = 1'b0;
    $display("test other done");
  endtask
  initial begin
    {errors, samples_checked} = '0;
    {rst, cfg_sram_mode, cfg_rom_translated, cyc_start, cyc_sys_mem, cyc_int_io} = 6'h20;
    {cyc_write, cyc_hi_byte, cyc_lo_byte, cyc_rom_direct_hit, cyc_rom_win_hit} = 5'h00;
    {cyc_addr, cyc_win_addr} = '0;
    repeat (2) @(negedge sys_clk);
    t_reset();
    rst = 1'b0;
    t_dram(24'h3A_5C96, 1'b1, 1'b1, 1'b0);
    t_dram(24'hC1_2345, 1'b1, 1'b0, 1'b1);
    t_sram();
    t_other();
    report_and_stop();
  end
endmodule
